/* File: lcs_charge_sequencer.sv */
// Charge sequencer for a single lithium-ion cell
`timescale 1ns/1ps

// Functional notes
// R1: Supply rising past threshold starts cycle
// R2: Cell below pre-charge threshold enters trickle
// R3: Trickle requests one tenth full rate
// R4: Trickle past one eighth timeout faults
// R5: Crossing pre-charge threshold starts full current
// R6: Regulation voltage reached switches to CV
// R7: Tenth-rate current enters EOC, releases indicator
// R8: After EOC charge until timeout, stop
// R9: Timeout before EOC is a fault
// R10: Below recharge after end restarts cycle
// R11: Inhibit watches cell, restarts below recharge
// R12: Indicator pair encodes charging, done, fault
// R13: Program pin out of range faults
// R14: Fault holds until re-enable or power cycle
// R15: Adapter present needs supply and margin
// R16: Enable low shuts down, floating enables
// R17: Thermal foldback scales current to zero
// R18: 22-bit counter steps per oscillator period
// R19: Timeout without completion pulls fault low
// R20: Counter clears at every new cycle
// R21: Pre-charge timeout when bit 19 sets
module lcs_charge_sequencer
	import lcs_pkg::*;
#(
	parameter logic [21:0] TIMEOUT_LAST = LCS_TMO_LAST  // Shorten for simulation
) (
	input  wire logic        clk_in,                   // 25 MHz system clock
	input  wire logic        rst_b_in,                 // Asynchronous reset, active low
	input  wire logic        en_in,                    // Enable pin, high when floating
	input  wire lcs_sense_t  sense_in,                 // Analog comparator results
	input  wire logic        osc_tick_in,              // Charge-timer oscillator output
	input  wire logic [3:0]  die_over_limit_in,        // Degrees above thermal limit
	output logic             charging_indicator_n_out, // Open-drain data, always low
	output logic             charging_indicator_oe_b_out, // Low while pulling low
	output logic             fault_n_out,              // Open-drain data, always low
	output logic             fault_oe_b_out,           // Low while pulling low
	output logic             adapter_present_output_out, // Adapter present
	output logic [6:0]       charge_pct_out,           // Current request in percent
	output logic             cv_mode_out,              // Hold regulation_voltage
	output lcs_state_t       state_out                 // Sequencer state
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	lcs_sense_t sense_m_r;     // First stage
	lcs_sense_t sense_s_r;     // Stable comparator results
	logic [3:0] temp_m_r;      // First stage
	logic [3:0] temp_s_r;      // Stable temperature excess
	logic       en_m_r;        // First stage
	logic       en_s_r;        // Stable enable
	logic       tick_m_r;      // First stage
	logic       tick_s_r;      // Stable oscillator level
	logic       tick_d_r;      // Delayed oscillator level

	// Two flops on everything from the analog side
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sense_m_r <= '0;
			sense_s_r <= '0;
			temp_m_r  <= 4'h0;
			temp_s_r  <= 4'h0;
			en_m_r    <= 1'b0;
			en_s_r    <= 1'b0;
			tick_m_r  <= 1'b0;
			tick_s_r  <= 1'b0;
			tick_d_r  <= 1'b0;
		end else begin
			sense_m_r <= sense_in;
			sense_s_r <= sense_m_r;
			temp_m_r  <= die_over_limit_in;
			temp_s_r  <= temp_m_r;
			en_m_r    <= en_in;
			en_s_r    <= en_m_r;
			tick_m_r  <= osc_tick_in;
			tick_s_r  <= tick_m_r;
			tick_d_r  <= tick_s_r;
		end
	end

	// ****************************************
	// Derived conditions
	// ****************************************
	logic        live;         // Enabled and powered
	logic        pin_bad;      // Program pin out of range
	logic        osc_tick;     // One pulse per oscillator period
	logic        tmo_full;     // Full timeout reached
	logic        tmo_pre;      // Pre-charge timeout reached
	logic [21:0] tmo_count;    // Timeout count
	logic        charging;     // Charge delivered in this state
	lcs_state_t  state_r;      // Sequencer state
	lcs_state_t  state_nxt;    // Next state

	assign live     = en_s_r && sense_s_r.supply_above_rise; // [R16]
	assign pin_bad  = sense_s_r.program_pin_high || sense_s_r.program_pin_low;
	assign osc_tick = tick_s_r && !tick_d_r;
	// One eighth of the full range, bit 19 at the default size
	assign tmo_pre  = (tmo_count >= 22'((23'(TIMEOUT_LAST) + 23'h00_0001) >> LCS_PRE_SHIFT));
	assign charging = (state_r == LCS_TRICKLE) || (state_r == LCS_CC) ||
		(state_r == LCS_CV) || (state_r == LCS_EOC);

	// ****************************************
	// Timeout counter
	// ****************************************
	// Cleared in the evaluation state, runs only while charging
	lcs_timeout_counter #(
		.LAST      (TIMEOUT_LAST)
	) u_timeout (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.clr_in    (state_r == LCS_EVAL || !live),   // [R20]
		.run_in    (charging),
		.tick_in   (osc_tick),                        // [R18]
		.count_out (tmo_count),
		.full_out  (tmo_full)
	);

	// ****************************************
	// Foldback arithmetic
	// ****************************************
	// Scale a percentage down linearly over the foldback span
	function automatic logic [6:0] fold(input logic [6:0] pct, input logic [3:0] over);
		logic [10:0] prod;
		prod = 11'h000;
		if (over >= LCS_FOLD_SPAN) begin
			fold = LCS_PCT_NONE;
		end else begin
			prod = 11'(pct) * 11'(LCS_FOLD_SPAN - over);
			fold = 7'(prod / 11'(LCS_FOLD_SPAN));
		end
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	// Transitions; shutdown is handled in the state register
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			// Power or enable just arrived
			LCS_OFF: begin
				state_nxt = LCS_EVAL;                          // [R1] [R14]
			end
			// Check the cell before charging
			LCS_EVAL: begin
				if (pin_bad) begin
					state_nxt = LCS_FAULT;                      // [R13]
				end else if (sense_s_r.cell_below_precharge) begin
					state_nxt = LCS_TRICKLE;                    // [R2]
				end else begin
					state_nxt = LCS_CC;
				end
			end
			// Pre-charge a deeply discharged cell
			LCS_TRICKLE: begin
				if (pin_bad || tmo_pre) begin
					state_nxt = LCS_FAULT;                      // [R4] [R13] [R21]
				end else if (!sense_s_r.cell_below_precharge) begin
					state_nxt = LCS_CC;                         // [R5]
				end
			end
			// Full-rate charge
			LCS_CC: begin
				if (pin_bad || tmo_full) begin
					state_nxt = LCS_FAULT;                      // [R9] [R13]
				end else if (sense_s_r.cell_at_regulation) begin
					state_nxt = LCS_CV;                         // [R6]
				end
			end
			// Hold the regulation voltage
			LCS_CV: begin
				if (pin_bad || tmo_full) begin
					state_nxt = LCS_FAULT;                      // [R9] [R19]
				end else if (sense_s_r.current_at_termination) begin
					state_nxt = LCS_EOC;                        // [R7]
				end
			end
			// Top off until the timer ends
			LCS_EOC: begin
				if (pin_bad) begin
					state_nxt = LCS_FAULT;                      // [R13]
				end else if (tmo_full) begin
					state_nxt = LCS_INHIBIT;                    // [R8]
				end
			end
			// Watch the cell without charging
			LCS_INHIBIT: begin
				if (sense_s_r.cell_below_recharge) begin
					state_nxt = LCS_EVAL;                       // [R10] [R11]
				end
			end
			// Stay until enable or power goes away
			LCS_FAULT: begin
				state_nxt = LCS_FAULT;                          // [R14]
			end
		endcase
	end

	// State register, shutdown overrides everything
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= LCS_OFF;
		end else if (!live) begin
			state_r <= LCS_OFF;                                 // [R16]
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Status pins
	// ****************************************
	// Indicator pair follows the state
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			charging_indicator_n_out    <= 1'b0;
			charging_indicator_oe_b_out <= 1'b1;
			fault_n_out                 <= 1'b0;
			fault_oe_b_out              <= 1'b1;
		end else begin
			charging_indicator_n_out    <= 1'b0;
			charging_indicator_oe_b_out <= !((state_nxt == LCS_TRICKLE) ||
				(state_nxt == LCS_CC) || (state_nxt == LCS_CV)) || !live; // [R7] [R12]
			fault_n_out                 <= 1'b0;
			fault_oe_b_out              <= !(state_nxt == LCS_FAULT) || !live; // [R12] [R19]
		end
	end

	// ****************************************
	// Charge request and adapter indicator
	// ****************************************
	// Request, mode and state copy lag the state register by one edge
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			charge_pct_out             <= LCS_PCT_NONE;
			cv_mode_out                <= 1'b0;
			state_out                  <= LCS_OFF;
			adapter_present_output_out <= 1'b0;
		end else begin
			unique case (state_r)
				LCS_TRICKLE: charge_pct_out <= fold(LCS_PCT_TRICKLE, temp_s_r); // [R3] [R17]
				LCS_CC, LCS_CV, LCS_EOC: charge_pct_out <= fold(LCS_PCT_FULL, temp_s_r);
				default: charge_pct_out <= LCS_PCT_NONE;
			endcase
			cv_mode_out                <= (state_r == LCS_CV) || (state_r == LCS_EOC); // [R6]
			state_out                  <= state_r;
			adapter_present_output_out <= sense_s_r.supply_above_rise &&
				sense_s_r.supply_above_cell;                        // [R15]
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	// Shutdown, then both indicators released
	sequence s_shut_then_released;
		(state_r == LCS_OFF) ##1 (charging_indicator_oe_b_out && fault_oe_b_out);
	endsequence

	// Voltage mode, then the mode output follows
	sequence s_cv_then_mode;
		(state_r == LCS_CV) ##1 cv_mode_out;
	endsequence

	// Timer end, then the request drops to nothing
	sequence s_stop_then_idle;
		(state_r == LCS_INHIBIT) ##1 (charge_pct_out == LCS_PCT_NONE);
	endsequence

	a_trickle_entry: assert property ( // [R2]
		(state_r == LCS_EVAL) && live && !pin_bad && sense_s_r.cell_below_precharge
		|=> (state_r == LCS_TRICKLE))
		else $error("deep cell did not enter trickle");
	a_trickle_rate: assert property ( // [R3]
		(state_r == LCS_TRICKLE) && (temp_s_r == 4'h0)
		|=> (charge_pct_out == LCS_PCT_TRICKLE))
		else $error("trickle request not one tenth");
	a_pre_timeout: assert property ( // [R4] [R21]
		(state_r == LCS_TRICKLE) && live && tmo_pre
		|=> (state_r == LCS_FAULT) && !fault_oe_b_out)
		else $error("pre-charge timeout not faulted");
	a_cc_entry: assert property ( // [R5]
		(state_r == LCS_TRICKLE) && live && !pin_bad && !tmo_pre &&
		!sense_s_r.cell_below_precharge |=> (state_r == LCS_CC))
		else $error("charged cell stayed in trickle");
	a_cv_switch: assert property ( // [R6]
		(state_r == LCS_CC) && live && !pin_bad && !tmo_full &&
		sense_s_r.cell_at_regulation |=> s_cv_then_mode)
		else $error("regulation reached without voltage mode");
	a_eoc_release: assert property ( // [R7]
		(state_r == LCS_CV) && live && !pin_bad && !tmo_full &&
		sense_s_r.current_at_termination
		|=> charging_indicator_oe_b_out && (state_r == LCS_EOC))
		else $error("termination did not release indicator");
	a_eoc_stop: assert property ( // [R8]
		(state_r == LCS_EOC) && live && !pin_bad && tmo_full |=> s_stop_then_idle)
		else $error("timer end did not stop the charge");
	a_timeout_fault: assert property ( // [R9] [R19]
		((state_r == LCS_CC) || (state_r == LCS_CV)) && live && tmo_full
		|=> (state_r == LCS_FAULT) && !fault_oe_b_out)
		else $error("timeout before end of charge not faulted");
	a_fault_hold: assert property ( // [R14]
		(state_r == LCS_FAULT) && live
		|=> (state_r == LCS_FAULT) && !fault_oe_b_out)
		else $error("fault left while enabled and powered");
	a_recharge_restart: assert property ( // [R10] [R11]
		(state_r == LCS_INHIBIT) && live && sense_s_r.cell_below_recharge
		|=> (state_r == LCS_EVAL))
		else $error("low cell did not restart charging");
	a_shutdown_release: assert property (!live |=> s_shut_then_released) // [R16]
		else $error("shutdown left an indicator driven");
	a_adapter_flag: assert property ( // [R15]
		adapter_present_output_out ==
		($past(sense_s_r.supply_above_rise) && $past(sense_s_r.supply_above_cell)))
		else $error("adapter flag disagrees with supply margin");
	a_count_clear: assert property ( // [R20]
		(state_r == LCS_EVAL) |=> (tmo_count == 22'h00_0000))
		else $error("counter not cleared at cycle start");
	a_pin_fault: assert property ( // [R13]
		charging && live && pin_bad |=> (state_r == LCS_FAULT))
		else $error("program pin fault missed");

endmodule

/* File: lcs_pkg.sv */
// Shared constants and types for the lithium-ion charge sequencer
package lcs_pkg;

	// ****************************************
	// Timeout counter
	// ****************************************
	localparam int          LCS_TMO_W     = 22;            // Counter width
	localparam logic [21:0] LCS_TMO_LAST  = 22'h3F_FFFF;   // Full timeout count
	localparam int          LCS_PRE_SHIFT = 3;             // Pre-charge limit is (last+1)/8

	// ****************************************
	// Charge current request, in percent
	// ****************************************
	localparam logic [6:0] LCS_PCT_FULL    = 7'h64;        // Full programmed rate
	localparam logic [6:0] LCS_PCT_TRICKLE = 7'h0A;        // Trickle rate
	localparam logic [6:0] LCS_PCT_NONE    = 7'h00;        // No charge
	localparam logic [3:0] LCS_FOLD_SPAN   = 4'hA;         // Degrees from limit to zero

	// ****************************************
	// Types
	// ****************************************
	// Comparator results from the analog front end, all active high
	typedef struct packed {
		logic supply_above_rise;      // Supply above power_on_threshold
		logic supply_above_cell;      // Supply at least the margin above the cell
		logic cell_below_precharge;   // Cell under the pre-charge threshold
		logic cell_at_regulation;     // Cell reached regulation_voltage
		logic cell_below_recharge;    // Cell under recharge_threshold
		logic current_at_termination; // Charge current down to termination_current
		logic program_pin_high;       // current_program_pin above upper limit
		logic program_pin_low;        // current_program_pin below lower limit
	} lcs_sense_t;

	// Sequencer states
	typedef enum logic [2:0] {
		LCS_OFF,      // Shutdown or no supply
		LCS_EVAL,     // New cycle, cell voltage check
		LCS_TRICKLE,  // Pre-charge
		LCS_CC,       // Constant current
		LCS_CV,       // Constant voltage
		LCS_EOC,      // End of charge, still charging
		LCS_INHIBIT,  // Charging ended, watching the cell
		LCS_FAULT     // Fault, charging stopped
	} lcs_state_t;

endpackage

/* File: lcs_timeout_counter.sv */
// Timeout counter stepped by the charge-timer oscillator
`timescale 1ns/1ps
module lcs_timeout_counter
	import lcs_pkg::*;
#(
	parameter logic [21:0] LAST = LCS_TMO_LAST  // Count that marks the timeout
) (
	input  wire logic        clk_in,    // System clock
	input  wire logic        rst_b_in,  // Asynchronous reset, active low
	input  wire logic        clr_in,    // Clear to zero
	input  wire logic        run_in,    // Counting allowed
	input  wire logic        tick_in,   // One oscillator period elapsed
	output logic      [21:0] count_out, // Current count
	output logic             full_out   // Count has reached LAST
);

	// ****************************************
	// Counter
	// ****************************************
	// Clear wins, then step on each tick while run_in is high, holding at the last count
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count_out <= 22'h00_0000;
		end else if (clr_in) begin
			count_out <= 22'h00_0000;
		end else if (run_in && tick_in && (count_out != LAST)) begin
			count_out <= count_out + 22'h00_0001;
		end
	end

	// Timeout reached
	assign full_out = (count_out == LAST);

	// Never steps past the last count
	a_count_saturates: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R18]
		(count_out == LAST) && !clr_in |=> (count_out == LAST))
		else $error("timeout counter left its last count");

endmodule

/* File: lcs_cell_model.sv */
// Behavioural cell, adapter and indicator pull-ups facing the sequencer
`timescale 1ns/1ps
module lcs_cell_model
	import lcs_pkg::*;
(
	input  wire logic        supply_ok_in,  // Supply above power_on_threshold
	input  wire logic        margin_ok_in,  // Supply margin above the cell
	input  wire logic [12:0] cell_mv_in,    // Cell voltage in mV
	input  wire logic [6:0]  cur_pct_in,    // Actual cell current in percent
	input  wire logic        pin_hi_in,     // Program pin above range
	input  wire logic        pin_lo_in,     // Program pin below range
	input  wire logic        chg_d_in,      // Charging pin data
	input  wire logic        chg_oe_b_in,   // Charging pin enable, low drives
	input  wire logic        flt_d_in,      // Fault pin data
	input  wire logic        flt_oe_b_in,   // Fault pin enable, low drives
	output lcs_sense_t       sense_out,     // Comparator levels
	output logic             chg_pin_out,   // Charging pin with pull-up
	output logic             flt_pin_out    // Fault pin with pull-up
);
	// ****************************************
	// Comparators
	// ****************************************
	always_comb begin
		sense_out.supply_above_rise      = supply_ok_in;
		sense_out.supply_above_cell      = margin_ok_in;
		sense_out.cell_below_precharge   = cell_mv_in < 13'h0AF0;  // 2.8 V
		sense_out.cell_at_regulation     = cell_mv_in >= 13'h1068; // 4.2 V
		sense_out.cell_below_recharge    = cell_mv_in < 13'h0FBE;  // 4.03 V
		sense_out.current_at_termination = cur_pct_in <= 7'h0A;
		sense_out.program_pin_high       = pin_hi_in;
		sense_out.program_pin_low        = pin_lo_in;
	end
	// Released pins float up to the pull-up level
	assign chg_pin_out = chg_oe_b_in ? 1'b1 : chg_d_in;
	assign flt_pin_out = flt_oe_b_in ? 1'b1 : flt_d_in;
endmodule

/* File: testbench.sv */
// Self-checking testbench for the charge sequencer
`timescale 1ns/1ps
module testbench;
	import lcs_pkg::*;
	logic        clk_in = 0, rst_b_in = 0, en_in = 0, osc = 0, sup = 0, mar = 0;
	logic        phi = 0, plo = 0, chg_d, chg_oe_b, flt_d, flt_oe_b, chg_pin, flt_pin;
	logic        adp, cvm;
	logic [12:0] mv = 13'h0E74;
	logic [6:0]  cur = 7'h64, pct;
	logic [3:0]  over = 4'h0;
	lcs_sense_t  sense;
	lcs_state_t  st;
	integer      n_fail = 0, n_compared = 0, cyc = 0, seed = 32'h9fe1, i;
	// ****************************************
	// Clock, oscillator and watchdog
	// ****************************************
	always #20 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		osc <= cyc[1];
		if (cyc == 4000) begin
			n_fail = n_fail + 1;
			finish_test();
		end
	end
	lcs_charge_sequencer #(.TIMEOUT_LAST(22'h00_003F)) i_lcs_charge_sequencer (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .en_in(en_in), .sense_in(sense),
		.osc_tick_in(osc), .die_over_limit_in(over),
		.charging_indicator_n_out(chg_d), .charging_indicator_oe_b_out(chg_oe_b),
		.fault_n_out(flt_d), .fault_oe_b_out(flt_oe_b), .adapter_present_output_out(adp),
		.charge_pct_out(pct), .cv_mode_out(cvm), .state_out(st));
	lcs_cell_model i_lcs_cell_model (
		.supply_ok_in(sup), .margin_ok_in(mar), .cell_mv_in(mv), .cur_pct_in(cur),
		.pin_hi_in(phi), .pin_lo_in(plo), .chg_d_in(chg_d), .chg_oe_b_in(chg_oe_b),
		.flt_d_in(flt_d), .flt_oe_b_in(flt_oe_b), .sense_out(sense),
		.chg_pin_out(chg_pin), .flt_pin_out(flt_pin));
	// ****************************************
	// Helpers
	// ****************************************
	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Let n edges pass, sample on the falling edge
	task automatic wt(input integer n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	// Check state and both indicator pins
	task automatic chk3(input lcs_state_t s, input logic c, input logic f);
		chk(st, s);
		chk(chg_pin, c);
		chk(flt_pin, f);
	endtask
	// Expected request under foldback
	function automatic logic [6:0] fold(input logic [6:0] b, input logic [3:0] o);
		fold = (o >= 4'hA) ? 7'h00 : 7'((b * (10 - o)) / 10);
	endfunction
	// Supply drop and return
	task automatic pwr_cycle();
		@(posedge clk_in) sup <= 0;
		wt(6);
		chk3(LCS_OFF, 1'b1, 1'b1);
		@(posedge clk_in) sup <= 1;
		wt(8);
	endtask
	// Verdict and end of run
	task automatic finish_test();
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		wt(3);
		chk3(LCS_OFF, 1'b1, 1'b1);
		chk(pct, 7'h00);
		@(posedge clk_in) rst_b_in <= 1;
		@(posedge clk_in) begin
			sup <= 1;
			mar <= 1;
			en_in <= 1;
		end
		wt(8);
		chk3(LCS_CC, 1'b0, 1'b1);
		chk(pct, 7'h64);
		chk(adp, 1'b1);
		chk(cvm, 1'b0);
		// Random excess, then the last step below and the first at the span
		for (i = 0; i < 8; i = i + 1) begin
			@(posedge clk_in) over <= (i < 6) ? 4'($random(seed)) : 4'(i + 3);
			wt(7);
			chk(pct, fold(7'h64, over));
		end
		@(posedge clk_in) begin
			over <= 4'h0;
			mv <= 13'h1068;
		end
		wt(6);
		chk(st, LCS_CV);
		chk(cvm, 1'b1);
		@(posedge clk_in) cur <= 7'h08;
		wt(6);
		chk3(LCS_EOC, 1'b1, 1'b1);
		chk(pct, 7'h64);
		wt(300);
		chk3(LCS_INHIBIT, 1'b1, 1'b1);
		chk(pct, 7'h00);
		@(posedge clk_in) begin
			mv <= 13'h0FA0;
			cur <= 7'h64;
		end
		wt(8);
		chk(st, LCS_CC);
		wt(200);
		chk(st, LCS_CC);
		wt(150);
		chk3(LCS_FAULT, 1'b1, 1'b0);
		chk(pct, 7'h00);
		@(posedge clk_in) mar <= 0;
		wt(6);
		chk(adp, 1'b0);
		@(posedge clk_in) begin
			mar <= 1;
			en_in <= 0;
		end
		wt(6);
		chk3(LCS_OFF, 1'b1, 1'b1);
		@(posedge clk_in) en_in <= 1;
		wt(8);
		chk(st, LCS_CC);
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge clk_in) begin
				phi <= (i == 0);
				plo <= (i == 1);
			end
			wt(6);
			chk3(LCS_FAULT, 1'b1, 1'b0);
			@(posedge clk_in) begin
				phi <= 0;
				plo <= 0;
			end
			pwr_cycle();
			chk(st, LCS_CC);
		end
		@(posedge clk_in) mv <= 13'h09C4;
		pwr_cycle();
		chk3(LCS_TRICKLE, 1'b0, 1'b1);
		chk(pct, 7'h0A);
		@(posedge clk_in) mv <= 13'h0BB8;
		wt(6);
		chk(st, LCS_CC);
		chk(pct, 7'h64);
		@(posedge clk_in) mv <= 13'h09C4;
		pwr_cycle();
		wt(60);
		chk3(LCS_FAULT, 1'b1, 1'b0);
		finish_test();
	end
endmodule
